// ---- pkg/nfs_pkg.sv ----
package nfs_pkg;
    localparam int ACC_W = 20;
    localparam int REG_W = 8;
    localparam int UPPER_W = 4;

    // Byte addresses of the word-aligned registers
    localparam logic [7:0] ADDR_CONTROL = 8'h00;
    localparam logic [7:0] ADDR_CLOCK = 8'h04;
    localparam logic [7:0] ADDR_ACC_LOW = 8'h08;
    localparam logic [7:0] ADDR_ACC_HIGH = 8'h0C;
    localparam logic [7:0] ADDR_ACC_UPPER = 8'h10;
    localparam logic [7:0] ADDR_INC_LOW = 8'h14;
    localparam logic [7:0] ADDR_INC_HIGH = 8'h18;
    localparam logic [7:0] ADDR_INC_UPPER = 8'h1C;
    localparam logic [7:0] ADDR_STATUS = 8'h20;

    localparam int BIT_ENABLE = 7;
    localparam int BIT_OUT_STATUS = 5;
    localparam int BIT_INVERT = 4;
    localparam int BIT_PULSE_MODE = 0;
    localparam int PWS_LSB = 5;
    localparam int CKS_LSB = 0;
    localparam int BIT_OVF_FLAG = 0;

    localparam logic [1:0] CKS_FAST_OSC = 2'h0;
    localparam logic [1:0] CKS_SYSTEM = 2'h1;
    localparam logic [1:0] CKS_LOGIC_CELL = 2'h2;

    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [7:0] INC_LOW_RESET = 8'h01;

    typedef struct packed {
        logic enable;
        logic invert;
        logic pulse_mode;
        logic [2:0] pulse_width;
        logic [1:0] clock_source;
    } nfs_cfg_type;
endpackage

// ---- verification/nfs_top_props.sv ----
`timescale 1ns/100ps
module nfs_top_props #(
    parameter int ACC_W = nfs_pkg::ACC_W
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic internal_fast_oscillator,
    input wire logic logic_cell_one_output,
    input wire logic nco_out,
    input wire logic overflow_interrupt_flag
);
    logic en_q;
    logic inv_q;
    logic [3:0] off_cnt_q;
    logic ctl_wr;
    logic rd_done;
    assign ctl_wr = psel && penable && pwrite && paddr == nfs_pkg::ADDR_CONTROL;
    assign rd_done = pready && !pwrite;
    // Shadow of enable and polarity as software last wrote them
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            en_q <= 1'b0;
            inv_q <= 1'b0;
        end else if (ctl_wr) begin
            en_q <= pwdata[nfs_pkg::BIT_ENABLE];
            inv_q <= pwdata[nfs_pkg::BIT_INVERT];
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            off_cnt_q <= 4'h0;
        end else if (en_q || ctl_wr) begin
            off_cnt_q <= 4'h0;
        end else if (off_cnt_q != 4'hF) begin
            off_cnt_q <= off_cnt_q + 4'h1;
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready held");
    ready_cause_a: assert property (pready |-> $past(psel && penable))
        else $error("ready without access");
    idle_data_a: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside ready");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("error without ready");
    upper_zero_a: assert property (rd_done && (paddr == nfs_pkg::ADDR_ACC_UPPER
        || paddr == nfs_pkg::ADDR_INC_UPPER) |-> prdata[31:ACC_W - 16] == '0)
        else $error("upper nibble read not zero");
    status_bit_a: assert property (rd_done && paddr == nfs_pkg::ADDR_CONTROL
        |-> prdata[5] == $past(nco_out) && prdata[6] == 1'b0 && prdata[3:1] == 3'h0)
        else $error("control read wrong");
    off_level_a: assert property (off_cnt_q >= 4'h4 |-> nco_out == inv_q)
        else $error("disabled output not idle");
    flag_hold_a: assert property ($fell(overflow_interrupt_flag) |-> $past(psel && penable
        && pwrite && paddr == nfs_pkg::ADDR_STATUS && pwdata[0]))
        else $error("flag cleared without write");
    flag_cause_a: assert property ($rose(overflow_interrupt_flag)
        |-> $past(en_q) || $past(en_q, 2) || $past(en_q, 3))
        else $error("flag set while disabled");
    cover property (pready && pslverr);
    cover property ($rose(overflow_interrupt_flag));
    cover property (en_q && nco_out != inv_q);
endmodule
bind nfs_top nfs_top_props #(.ACC_W(ACC_W)) nfs_top_props_inst (.clk(clk), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .nco_out(nco_out),
    .internal_fast_oscillator(internal_fast_oscillator),
    .logic_cell_one_output(logic_cell_one_output),
    .overflow_interrupt_flag(overflow_interrupt_flag));

// ---- verification/test_nfs_top.sv ----
`timescale 1ns/100ps
module test_nfs_top;
    logic clk, rst, psel, penable, pwrite, fo, lc, pready, pslverr, nco_out, flag, inv, pend;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [32:0] q[$];
    logic [19:0] acc, incv, bufv;
    logic [20:0] sum;
    logic [1:0] src;
    int n_mismatch, checked, nov, act;
    nfs_top nfs_top_inst (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .internal_fast_oscillator(fo), .logic_cell_one_output(lc), .nco_out(nco_out),
        .overflow_interrupt_flag(flag));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic close_out();
        if (n_mismatch == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n = 0;
        @(posedge clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, 24'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        {psel, penable} <= 2'h0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic e, input logic [7:0] d);
        q.push_back({e, 24'h0, d});
        apb(1'b0, a, 8'h00);
    endtask
    // Upper and high first, low last, since the low byte arms the buffer
    task automatic wr3(input logic [7:0] a, input logic [19:0] v);
        wr(a + 8'h08, {4'h0, v[19:16]});
        wr(a + 8'h04, v[15:8]);
        wr(a, v[7:0]);
    endtask
    // Selected line: one input period of 4 clocks; the other line toggles as decoy
    task automatic pulses(input int n);
        for (int i = 0; i < n; i++) begin
            for (int k = 0; k < 4; k++) begin
                @(posedge clk);
                act += int'(nco_out !== inv);
                fo <= src == 2'h2 ? k[0] : k < 2;
                lc <= src == 2'h2 ? k < 2 : k[0];
            end
            if (src != 2'h3) begin
                sum = {1'b0, acc} + {1'b0, bufv};
                acc = sum[19:0];
                nov += int'(sum[20]);
                bufv = pend ? incv : bufv;
                pend = 1'b0;
            end
        end
        @(posedge clk);
        {fo, lc} <= 2'h0;
    endtask
    always @(posedge clk) begin
        if (pready === 1'b1 && pwrite === 1'b0) begin
            chk({pslverr, prdata}, q.size() > 0 ? q.pop_front() : 33'h1FFFFFFFF);
        end
    end
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        close_out();
    end
    initial begin
        {rst, psel, penable, pwrite, fo, lc, pend, inv, src, paddr, pwdata} = 50'h2_0000_0000_0000;
        {n_mismatch, checked, nov, act} = '0;
        void'($urandom(32'hC9869994));
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 8; i++) rd(8'(4 * i), 1'b0, i == 5 ? 8'h01 : 8'h00);
        rd(8'h24, 1'b1, 8'h00);
        wr(nfs_pkg::ADDR_CONTROL, 8'h5F);
        wr(nfs_pkg::ADDR_CLOCK, 8'hFF);
        wr(nfs_pkg::ADDR_ACC_UPPER, 8'hFF);
        wr(nfs_pkg::ADDR_INC_UPPER, 8'hFF);
        rd(nfs_pkg::ADDR_CONTROL, 1'b0, 8'h31);
        rd(nfs_pkg::ADDR_CLOCK, 1'b0, 8'hE3);
        rd(nfs_pkg::ADDR_ACC_UPPER, 1'b0, 8'h0F);
        rd(nfs_pkg::ADDR_INC_UPPER, 1'b0, 8'h0F);
        for (int j = 0; j < 6; j++) begin
            src = j % 3 == 2 ? 2'h3 : 2'(2 * (j % 3));
            acc = 20'($urandom());
            incv = 20'($urandom());
            bufv = incv;
            nov = 0;
            wr3(nfs_pkg::ADDR_ACC_LOW, acc);
            wr3(nfs_pkg::ADDR_INC_LOW, incv);
            wr(nfs_pkg::ADDR_CLOCK, {3'($urandom()), 3'h0, src});
            wr(nfs_pkg::ADDR_CONTROL, 8'h80);
            pulses(3 + $urandom_range(5));
            incv = 20'($urandom());
            wr3(nfs_pkg::ADDR_INC_LOW, incv);
            pend = 1'b1;
            pulses(4);
            repeat (3) @(posedge clk);
            chk(33'(nco_out), 33'(nov[0]));
            rd(nfs_pkg::ADDR_STATUS, 1'b0, 8'(nov > 0));
            chk(33'(flag), 33'(nov > 0));
            wr(nfs_pkg::ADDR_CONTROL, 8'h00);
            rd(nfs_pkg::ADDR_ACC_LOW, 1'b0, acc[7:0]);
            rd(nfs_pkg::ADDR_ACC_HIGH, 1'b0, acc[15:8]);
            rd(nfs_pkg::ADDR_ACC_UPPER, 1'b0, {4'h0, acc[19:16]});
            wr(nfs_pkg::ADDR_STATUS, 8'h01);
            rd(nfs_pkg::ADDR_STATUS, 1'b0, 8'h00);
        end
        // System clock source: eight enabled edges give four rising input edges
        acc = 20'($urandom());
        incv = 20'($urandom());
        wr3(nfs_pkg::ADDR_ACC_LOW, acc);
        wr3(nfs_pkg::ADDR_INC_LOW, incv);
        wr(nfs_pkg::ADDR_CLOCK, 8'h01);
        wr(nfs_pkg::ADDR_CONTROL, 8'h80);
        repeat (4) @(posedge clk);
        wr(nfs_pkg::ADDR_CONTROL, 8'h00);
        acc = acc + 20'(incv << 2);
        rd(nfs_pkg::ADDR_ACC_LOW, 1'b0, acc[7:0]);
        rd(nfs_pkg::ADDR_ACC_HIGH, 1'b0, acc[15:8]);
        rd(nfs_pkg::ADDR_ACC_UPPER, 1'b0, {4'h0, acc[19:16]});
        for (int w = 0; w < 4; w++) begin
            inv = 1'($urandom());
            src = 2'h0;
            incv = 20'h40000 >> w;
            bufv = incv;
            wr3(nfs_pkg::ADDR_ACC_LOW, 20'h0);
            wr3(nfs_pkg::ADDR_INC_LOW, incv);
            wr(nfs_pkg::ADDR_CLOCK, 8'(w << 5));
            wr(nfs_pkg::ADDR_CONTROL, {3'h4, inv, 4'h1});
            act = 0;
            pulses((10 << w) + 1);
            chk(33'(act), 33'(8 << w));
            wr(nfs_pkg::ADDR_CONTROL, {3'h0, inv, 4'h0});
            repeat (4) @(posedge clk);
            rd(nfs_pkg::ADDR_CONTROL, 1'b0, {2'h0, inv, inv, 4'h0});
        end
        repeat (4) @(posedge clk);
        close_out();
    end
endmodule

// ---- verilog/nfs_clock_select.sv ----
`timescale 1ns/100ps
// Samples the chosen source and reports its rising and falling edges
module nfs_clock_select (
    input wire logic clk,
    input wire logic rst,
    input wire logic [1:0] clock_source_select,
    input wire logic internal_fast_oscillator,
    input wire logic logic_cell_one_output,
    output logic rise,
    output logic fall
);
    logic src;
    logic prev_q;
    logic sys_q;

    always_comb begin
        if (clock_source_select == nfs_pkg::CKS_FAST_OSC) begin
            src = internal_fast_oscillator;
        end else if (clock_source_select == nfs_pkg::CKS_LOGIC_CELL) begin
            src = logic_cell_one_output;
        end else begin
            src = 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prev_q <= 1'b0;
        end else begin
            prev_q <= src;
        end
    end

    // System clock source: one rise and one fall every two cycles
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sys_q <= 1'b0;
        end else begin
            sys_q <= ~sys_q;
        end
    end

    always_comb begin
        if (clock_source_select == nfs_pkg::CKS_SYSTEM) begin
            rise = ~sys_q;
            fall = sys_q;
        end else begin
            rise = src & ~prev_q;
            fall = ~src & prev_q;
        end
    end
endmodule

// ---- verilog/nfs_pulse_stretch.sv ----
`timescale 1ns/100ps
// Holds the pulse active for 2**width input clock periods
module nfs_pulse_stretch #(
    parameter int CNT_W = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic tick,
    input wire logic start,
    input wire logic clear,
    input wire logic [2:0] width_sel,
    output logic active
);
    logic [CNT_W-1:0] left_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            left_q <= '0;
        end else if (clear) begin
            left_q <= '0;
        end else if (tick && start) begin
            left_q <= CNT_W'(1) << width_sel;
        end else if (tick && left_q != '0) begin
            left_q <= left_q - CNT_W'(1);
        end
    end

    assign active = (left_q != '0);
endmodule

// ---- verilog/nfs_top.sv ----
// Implementation choices: the register offsets and the APB slave port.
`timescale 1ns/100ps
// Behaviour
// - Oscillator runs only while the enable bit is set.
// - Read-only status bit shows present output level.
// - Polarity bit inverts the output signal.
// - Mode bit selects pulse mode when set, divide-by-two toggle when clear.
// - Pulse width field gives two to the field value input periods.
// - Pulse width applies only in pulse mode.
// - Clock source: 00 fast oscillator, 01 system clock, 10 logic cell.
// - Accumulator readable as three bytes, upper nibble reads zero.
// - Accumulator runs freely; no atomic multi-byte access.
// - Increment formed from low, high and upper byte registers.
// - Accumulator adds a hidden buffered copy of the increment.
// - Low increment write loads the buffer on next input clock fall, or at once while disabled.
// - Each input rising edge adds buffered increment; bit 19 carry is overflow.
// - Fixed duty mode toggles the output on every overflow.
// - Pulse mode goes active on the rising edge after overflow.
// - Overflow sets a sticky flag until software clears it.
module nfs_top #(
    parameter int ACC_W = nfs_pkg::ACC_W
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic internal_fast_oscillator,
    input wire logic logic_cell_one_output,
    output logic nco_out,
    output logic overflow_interrupt_flag
);
    nfs_pkg::nfs_cfg_type cfg_q;
    logic [ACC_W-1:0] phase_accumulator_q;
    logic [ACC_W-1:0] increment_value_q;
    logic [ACC_W-1:0] increment_buffer_q;
    logic load_pending_q;
    logic toggle_q;
    logic pending_pulse_q;
    logic rise;
    logic fall;
    logic pulse_active;
    logic [ACC_W:0] sum;
    logic overflow;
    logic core_level;
    logic out_level;
    logic wr;
    logic rd;
    logic [7:0] wbyte;
    logic [7:0] rbyte;
    logic addr_ok;

    localparam int UPPER_W_F = nfs_pkg::UPPER_W;

    function automatic logic [7:0] nibble_byte(input logic [UPPER_W_F-1:0] v);
        nibble_byte = {4'h0, v};
    endfunction

    assign wr = psel && penable && pwrite;
    assign rd = psel && penable && !pwrite;
    assign wbyte = pwdata[7:0];

    nfs_clock_select u_clock_select (
        .clk(clk),
        .rst(rst),
        .clock_source_select(cfg_q.clock_source),
        .internal_fast_oscillator(internal_fast_oscillator),
        .logic_cell_one_output(logic_cell_one_output),
        .rise(rise),
        .fall(fall)
    );

    // Control and clock registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cfg_q <= '0;
        end else if (wr && paddr == nfs_pkg::ADDR_CONTROL) begin
            cfg_q.enable <= wbyte[nfs_pkg::BIT_ENABLE];
            cfg_q.invert <= wbyte[nfs_pkg::BIT_INVERT];
            cfg_q.pulse_mode <= wbyte[nfs_pkg::BIT_PULSE_MODE];
        end else if (wr && paddr == nfs_pkg::ADDR_CLOCK) begin
            cfg_q.pulse_width <= wbyte[nfs_pkg::PWS_LSB +: 3];
            cfg_q.clock_source <= wbyte[nfs_pkg::CKS_LSB +: 2];
        end
    end

    // Increment registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            increment_value_q <= {12'h000, nfs_pkg::INC_LOW_RESET};
        end else if (wr && paddr == nfs_pkg::ADDR_INC_LOW) begin
            increment_value_q[7:0] <= wbyte;
        end else if (wr && paddr == nfs_pkg::ADDR_INC_HIGH) begin
            increment_value_q[15:8] <= wbyte;
        end else if (wr && paddr == nfs_pkg::ADDR_INC_UPPER) begin
            increment_value_q[19:16] <= wbyte[3:0];
        end
    end

    // Buffer loads on next falling input edge, or at once when disabled
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            load_pending_q <= 1'b0;
        end else if (wr && paddr == nfs_pkg::ADDR_INC_LOW) begin
            load_pending_q <= 1'b1;
        end else if (!cfg_q.enable || fall) begin
            load_pending_q <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            increment_buffer_q <= {12'h000, nfs_pkg::INC_LOW_RESET};
        end else if (load_pending_q && (fall || !cfg_q.enable)) begin
            increment_buffer_q <= increment_value_q;
        end
    end

    assign sum = {1'b0, phase_accumulator_q} + {1'b0, increment_buffer_q};
    assign overflow = cfg_q.enable && rise && sum[ACC_W];

    // Accumulator: free-running, also byte-writable
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            phase_accumulator_q <= '0;
        end else if (wr && paddr == nfs_pkg::ADDR_ACC_LOW) begin
            phase_accumulator_q[7:0] <= wbyte;
        end else if (wr && paddr == nfs_pkg::ADDR_ACC_HIGH) begin
            phase_accumulator_q[15:8] <= wbyte;
        end else if (wr && paddr == nfs_pkg::ADDR_ACC_UPPER) begin
            phase_accumulator_q[19:16] <= wbyte[3:0];
        end else if (cfg_q.enable && rise) begin
            phase_accumulator_q <= sum[ACC_W-1:0];
        end
    end

    // Fixed duty toggle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            toggle_q <= 1'b0;
        end else if (!cfg_q.enable) begin
            toggle_q <= 1'b0;
        end else if (overflow) begin
            toggle_q <= ~toggle_q;
        end
    end

    // Pulse starts on the rising edge after overflow
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pending_pulse_q <= 1'b0;
        end else if (!cfg_q.enable) begin
            pending_pulse_q <= 1'b0;
        end else if (overflow) begin
            pending_pulse_q <= 1'b1;
        end else if (rise) begin
            pending_pulse_q <= 1'b0;
        end
    end

    nfs_pulse_stretch u_pulse_stretch (
        .clk(clk),
        .rst(rst),
        .tick(rise),
        .start(pending_pulse_q),
        .clear(!cfg_q.enable),
        .width_sel(cfg_q.pulse_width),
        .active(pulse_active)
    );

    // Mode select, then polarity as the last stage
    assign core_level = cfg_q.pulse_mode ? pulse_active : toggle_q;
    assign out_level = core_level ^ cfg_q.invert;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            nco_out <= 1'b0;
        end else begin
            nco_out <= out_level;
        end
    end

    // Sticky overflow flag: set wins over software clear
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            overflow_interrupt_flag <= 1'b0;
        end else if (overflow) begin
            overflow_interrupt_flag <= 1'b1;
        end else if (wr && paddr == nfs_pkg::ADDR_STATUS && wbyte[nfs_pkg::BIT_OVF_FLAG]) begin
            overflow_interrupt_flag <= 1'b0;
        end
    end

    // Read mux
    always_comb begin
        rbyte = nfs_pkg::RESET_BYTE;
        addr_ok = 1'b1;
        if (paddr == nfs_pkg::ADDR_CONTROL) begin
            rbyte[nfs_pkg::BIT_ENABLE] = cfg_q.enable;
            rbyte[nfs_pkg::BIT_OUT_STATUS] = nco_out;
            rbyte[nfs_pkg::BIT_INVERT] = cfg_q.invert;
            rbyte[nfs_pkg::BIT_PULSE_MODE] = cfg_q.pulse_mode;
        end else if (paddr == nfs_pkg::ADDR_CLOCK) begin
            rbyte[nfs_pkg::PWS_LSB +: 3] = cfg_q.pulse_width;
            rbyte[nfs_pkg::CKS_LSB +: 2] = cfg_q.clock_source;
        end else if (paddr == nfs_pkg::ADDR_ACC_LOW) begin
            rbyte = phase_accumulator_q[7:0];
        end else if (paddr == nfs_pkg::ADDR_ACC_HIGH) begin
            rbyte = phase_accumulator_q[15:8];
        end else if (paddr == nfs_pkg::ADDR_ACC_UPPER) begin
            rbyte = nibble_byte(phase_accumulator_q[19:16]);
        end else if (paddr == nfs_pkg::ADDR_INC_LOW) begin
            rbyte = increment_value_q[7:0];
        end else if (paddr == nfs_pkg::ADDR_INC_HIGH) begin
            rbyte = increment_value_q[15:8];
        end else if (paddr == nfs_pkg::ADDR_INC_UPPER) begin
            rbyte = nibble_byte(increment_value_q[19:16]);
        end else if (paddr == nfs_pkg::ADDR_STATUS) begin
            rbyte[nfs_pkg::BIT_OVF_FLAG] = overflow_interrupt_flag;
        end else begin
            addr_ok = 1'b0;
        end
    end

    // APB answer: one wait state, ready in the access cycle's second edge
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end else if (psel && penable && !pready) begin
            pready <= 1'b1;
            pslverr <= !addr_ok;
            prdata <= rd ? {24'h000000, rbyte} : 32'h00000000;
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end
    end
endmodule
